// ### igw_error_flags.sv
// error detection and flag logic of a gateway output node, apb register side
// assumes host resume and word-taken inputs synchronous to mclk
// Function
// - resume while idle sets sequence error
// - sequence error sets output error summary
// - writing zero to clear bit8 clears it
// - disconnect write terminates the output transfer
// - check word before storing output data
// - regenerate check bits and compare
// - single error: correct; flag and capture syndrome only while multi flag clear
// - syndrome identifies corrected halfword bit
// - single flag sticky, latest syndrome kept
// - multi error resets single flag, first syndrome
// - multi error: no correction, flag, syndrome
// - multi flag sticky, first syndrome kept
// - syndrome clear resets flags, keeps syndrome
// - clear register bits 1, 6, 8
// - summary bit 11 raises masked interrupt
// - secded flags raise masked interrupt
`timescale 1ns/100ps
module igw_error_flags (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire igw_pkg::igw_apb_req_t apb_req,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  host_resume,
  input  wire logic                  host_word_taken,
  output logic [igw_pkg::DATA_W-1:0] out_word,
  output logic                       out_word_valid,
  output logic                       out_disconnect,
  output logic                       out_active,
  output logic                       io_irq
);
  import igw_pkg::*;

  logic [31:0]         data_lo_reg;
  logic [31:0]         data_hi_reg;
  logic [DATA_W-1:0]   out_word_reg;
  logic                out_valid_reg;
  logic                active_reg;
  logic                disc_reg;
  logic                done_reg;
  logic                seq_err_reg;
  logic                single_reg;
  logic                multi_reg;
  logic [CHECK_W-1:0]  syn_reg;
  logic [31:0]         mask_reg;
  logic [31:0]         prdata_reg;
  logic [31:0]         flag_view;
  logic                access;
  logic                wr;
  logic                hit;
  logic                wr_check;
  logic                wr_disc;
  logic                wr_clear;
  logic                wr_synclr;
  logic                wr_flags;
  logic                seq_event;
  igw_chk_res_t        chk;
  logic [DATA_W-1:0]   fix_data;
  logic [CHECK_W-1:0]  fix_syn;
  logic [1:0]          half_single;
  logic [1:0]          half_multi;

  // apb decode; slave is always ready, so access lasts one cycle
  assign access    = apb_req.psel && apb_req.penable;
  assign wr        = access && apb_req.pwrite;
  assign pready    = 1'b1;
  always_comb begin
    case (apb_req.paddr)
      OFS_IRQ_FLAGS, OFS_IRQ_MASK, OFS_CLEAR, OFS_SYNDROME, OFS_SYN_CLR,
      OFS_DISCONNECT, OFS_DATA_LO, OFS_DATA_HI, OFS_CHECK, OFS_IO_ERROR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr   = access && !hit;
  assign wr_check  = wr && (apb_req.paddr == OFS_CHECK);
  assign wr_disc   = wr && (apb_req.paddr == OFS_DISCONNECT);
  assign wr_clear  = wr && (apb_req.paddr == OFS_CLEAR);
  assign wr_synclr = wr && (apb_req.paddr == OFS_SYN_CLR);
  assign wr_flags  = wr && (apb_req.paddr == OFS_IRQ_FLAGS);

  // secded on both halfwords, 7 check bits each
  for (genvar h = 0; h < 2; h++) begin : g_half
    igw_secded_half u_half (
      .data_in    (h == 0 ? data_lo_reg : data_hi_reg),
      .check_in   (apb_req.pwdata[h*HALF_CW +: HALF_CW]),
      .data_out   (fix_data[h*32 +: 32]),
      .syndrome   (fix_syn[h*HALF_CW +: HALF_CW]),
      .single_err (half_single[h]),
      .multi_err  (half_multi[h])
    );
  end
  // a halfword with a double error makes the whole word multi
  assign chk = '{data:       fix_data,
                 syndrome:   fix_syn,
                 single_err: !(|half_multi) && (|half_single),
                 multi_err:  |half_multi};

  // data words staged until the check write commits them
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_lo_reg <= 32'h0000_0000;
      data_hi_reg <= 32'h0000_0000;
    end else if (wr && apb_req.paddr == OFS_DATA_LO) begin
      data_lo_reg <= apb_req.pwdata;
    end else if (wr && apb_req.paddr == OFS_DATA_HI) begin
      data_hi_reg <= apb_req.pwdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_word_reg  <= 64'h0000_0000_0000_0000;
      out_valid_reg <= 1'b0;
    end else if (wr_check) begin
      // uncorrectable words pass unchanged; software sees the flag
      out_word_reg  <= chk.multi_err ? {data_hi_reg, data_lo_reg} : chk.data;
      out_valid_reg <= 1'b1;
    end else if ((wr_clear && apb_req.pwdata[CLR_BUF_PRIO]) || host_word_taken) begin
      out_valid_reg <= 1'b0;
    end
  end

  // output transfer control
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      active_reg <= 1'b0;
      disc_reg   <= 1'b0;
    end else begin
      disc_reg <= wr_disc;
      if (wr_check) begin
        active_reg <= 1'b1;
      end else if (wr_disc || (wr_clear && apb_req.pwdata[CLR_OUT_CTRL])) begin
        active_reg <= 1'b0;
      end
    end
  end

  // output complete: set when the host drains the word, cleared by next word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
    end else if (out_valid_reg && host_word_taken) begin
      done_reg <= 1'b1;
    end else if (wr_check || wr_disc || (wr_flags && apb_req.pwdata[FLG_OUT_DONE])) begin
      done_reg <= 1'b0;
    end
  end

  assign seq_event = host_resume && !active_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seq_err_reg <= 1'b0;
    end else if (seq_event) begin
      seq_err_reg <= 1'b1;
    end else if ((wr_clear && !apb_req.pwdata[CLR_OUT_ERR]) ||
                 (wr_flags && apb_req.pwdata[FLG_OUT_ERR])) begin
      seq_err_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      single_reg <= 1'b0;
    end else if (wr_check && chk.multi_err) begin
      single_reg <= 1'b0;
    end else if (wr_check && chk.single_err && !multi_reg) begin
      single_reg <= 1'b1;
    end else if (wr_synclr || (wr_flags && apb_req.pwdata[FLG_SINGLE])) begin
      single_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      multi_reg <= 1'b0;
    end else if (wr_check && chk.multi_err) begin
      multi_reg <= 1'b1;
    end else if (wr_synclr || (wr_flags && apb_req.pwdata[FLG_MULTI])) begin
      multi_reg <= 1'b0;
    end
  end

  // first multi syndrome kept
  // syndrome survives flag clears; it is only meaningful while a flag is up
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      syn_reg <= 14'h0000;
    end else if (wr_check && !multi_reg && (chk.multi_err || chk.single_err)) begin
      syn_reg <= chk.syndrome;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mask_reg <= MASK_RESET;
    end else if (wr && apb_req.paddr == OFS_IRQ_MASK) begin
      mask_reg <= apb_req.pwdata;
    end
  end

  always_comb begin
    flag_view               = 32'h0000_0000;
    flag_view[FLG_SINGLE]   = single_reg;
    flag_view[FLG_MULTI]    = multi_reg;
    flag_view[FLG_OUT_DONE] = done_reg;
    flag_view[FLG_OUT_ERR]  = seq_err_reg;
  end

  // read data captured in the setup phase, stable through access
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_req.psel && !apb_req.penable) begin
      case (apb_req.paddr)
        OFS_IRQ_FLAGS: prdata_reg <= flag_view;
        OFS_IRQ_MASK:  prdata_reg <= mask_reg;
        OFS_SYNDROME:  prdata_reg <= {18'h0_0000, syn_reg};
        OFS_DATA_LO:   prdata_reg <= data_lo_reg;
        OFS_DATA_HI:   prdata_reg <= data_hi_reg;
        OFS_IO_ERROR:  prdata_reg <= {20'h0_0000, seq_err_reg, 11'h000};
        default:       prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata         = prdata_reg;
  assign out_word       = out_word_reg;
  assign out_word_valid = out_valid_reg;
  assign out_disconnect = disc_reg;
  assign out_active     = active_reg;
  assign io_irq         = |(flag_view & mask_reg);

  a_seq_err_set: assert property (@(posedge mclk) disable iff (sys_rst)
    host_resume && !active_reg |=> seq_err_reg)
    else $error("resume while idle did not set sequence error");

  a_summary_bit: assert property (@(posedge mclk) disable iff (sys_rst)
    seq_event |=> flag_view[FLG_OUT_ERR] && seq_err_reg)
    else $error("summary flag missing after sequence error");

  a_seq_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_clear && !apb_req.pwdata[CLR_OUT_ERR] && !seq_event |=> !seq_err_reg)
    else $error("sequence error not cleared");

  a_disc_ends: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_disc && !wr_check |=> out_disconnect && !out_active)
    else $error("disconnect did not end transfer");

  a_store_checked: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_check && !chk.multi_err |=> out_word_valid && out_word == $past(chk.data))
    else $error("stored word is not the checked word");

  a_multi_raw: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_check && chk.multi_err |=> out_word == $past({data_hi_reg, data_lo_reg}))
    else $error("multi error word was altered");

  a_single_keep: assert property (@(posedge mclk) disable iff (sys_rst)
    single_reg && !wr_synclr && !wr_flags && !(wr_check && chk.multi_err) |=> single_reg)
    else $error("single flag dropped without clear");

  a_clear_buf: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_clear && apb_req.pwdata[CLR_BUF_PRIO] |=> !out_word_valid)
    else $error("buffer clear left a staged word");

  a_single_capture: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_check && chk.single_err && !multi_reg |=> single_reg && syn_reg == $past(chk.syndrome))
    else $error("single error not flagged or syndrome not captured");

  a_multi_single: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_check && chk.multi_err |=> multi_reg && !single_reg)
    else $error("multi error flag handling wrong");

  a_multi_keeps: assert property (@(posedge mclk) disable iff (sys_rst)
    multi_reg && !wr_synclr && !wr_flags ##1 wr_check |=> multi_reg && $stable(syn_reg))
    else $error("first multi syndrome not kept");

  a_syn_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_synclr |=> !single_reg && !multi_reg && $stable(syn_reg))
    else $error("syndrome clear misbehaved");

  a_irq_level: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(seq_err_reg) && mask_reg[FLG_OUT_ERR] |-> io_irq)
    else $error("masked-in summary did not raise interrupt");

  a_secded_irq: assert property (@(posedge mclk) disable iff (sys_rst)
    (single_reg && mask_reg[FLG_SINGLE]) || (multi_reg && mask_reg[FLG_MULTI]) |-> io_irq)
    else $error("masked-in secded flag did not raise interrupt");
endmodule : igw_error_flags

// ### igw_pkg.sv
// shared constants and carriers for the gateway error and secded flag block
// assumes a 32-bit apb slave and 64-bit words with 14 check bits
package igw_pkg;
  localparam int DATA_W  = 64;
  localparam int CHECK_W = 14;
  localparam int HALF_CW = 7;
  localparam int ADDR_W  = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CLEAR      = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SYNDROME   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SYN_CLR    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DISCONNECT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DATA_LO    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_DATA_HI    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CHECK      = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IO_ERROR   = 8'h24;

  // interrupt flag and mask fields
  localparam int FLG_SINGLE   = 1;
  localparam int FLG_MULTI    = 2;
  localparam int FLG_OUT_DONE = 10;
  localparam int FLG_OUT_ERR  = 11;
  // io error field
  localparam int ERR_SEQ      = 11;
  // clear register fields
  localparam int CLR_OUT_CTRL = 1;
  localparam int CLR_BUF_PRIO = 6;
  localparam int CLR_OUT_ERR  = 8;

  localparam logic [31:0] MASK_RESET = 32'h0000_0000;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } igw_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0]  data;
    logic [CHECK_W-1:0] syndrome;
    logic               single_err;
    logic               multi_err;
  } igw_chk_res_t;
endpackage : igw_pkg

// ### igw_secded_half.sv
// single-error-correct double-error-detect check on one 32-bit halfword
// assumes 6 hamming bits plus one overall parity bit per halfword
`timescale 1ns/100ps
module igw_secded_half (
  input  wire logic [31:0] data_in,
  input  wire logic [6:0]  check_in,
  output logic      [31:0] data_out,
  output logic      [6:0]  syndrome,
  output logic             single_err,
  output logic             multi_err
);
  import igw_pkg::*;

  // codeword position of data bit idx, skipping powers of two
  function automatic logic [5:0] dpos(input int idx);
    int         n;
    logic [5:0] r;
    n = 0;
    r = 6'h00;
    for (int k = 3; k < 64; k++) begin
      if ((k & (k - 1)) != 0) begin
        if (n == idx) begin
          r = k[5:0];
        end
        n++;
      end
    end
    return r;
  endfunction : dpos

  logic [5:0] calc;
  logic [5:0] syn6;
  logic       par_bad;

  always_comb begin
    calc = 6'h00;
    for (int i = 0; i < 32; i++) begin
      calc = calc ^ ({6{data_in[i]}} & dpos(i));
    end
  end

  assign syn6       = calc ^ check_in[5:0];
  assign par_bad    = (^data_in) ^ (^check_in);
  assign single_err = par_bad;
  assign multi_err  = !par_bad && (syn6 != 6'h00);
  assign syndrome   = {par_bad, syn6};

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      data_out[i] = data_in[i] ^ (par_bad && (dpos(i) == syn6));
    end
  end
endmodule : igw_secded_half

// ### igw_host_model.sv
// host side model of the low speed output channel
// assumes one mclk domain; drives resume and word-taken
`timescale 1ns/100ps
module igw_host_model (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       hold,
  input  wire logic [3:0] take_delay,
  input  wire logic       out_word_valid,
  input  wire logic       out_disconnect,
  output logic            host_resume,
  output logic            host_word_taken
);
  logic [3:0] cnt;
  int         disc_count;

  initial host_resume = 1'b0;

  // slow drain, one pulse per word so a word is never taken twice
  always_ff @(posedge mclk) begin
    if (sys_rst || !out_word_valid || hold || host_word_taken) begin
      cnt             <= 4'h0;
      host_word_taken <= 1'b0;
    end else begin
      cnt             <= cnt + 4'h1;
      host_word_taken <= (cnt == take_delay);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      disc_count <= 0;
    end else if (out_disconnect) begin
      disc_count <= disc_count + 1;
    end
  end

  task automatic pulse_resume;
    @(posedge mclk);
    host_resume <= 1'b1;
    @(posedge mclk);
    host_resume <= 1'b0;
  endtask : pulse_resume
endmodule : igw_host_model

// ### io_gateway_error_secded_flags_tb_top.sv
// self-checking bench for the gateway error and secded flag block
// assumes one 40 MHz clock; this module is the apb master
`timescale 1ns/100ps
module io_gateway_error_secded_flags_tb_top;
  import igw_pkg::*;
  logic                   mclk = 1'b0;
  logic                   sys_rst;
  igw_apb_req_t           req;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   host_resume;
  logic                   host_word_taken;
  logic [DATA_W-1:0]      out_word;
  logic                   out_word_valid;
  logic                   out_disconnect;
  logic                   out_active;
  logic                   io_irq;
  logic                   hold;
  logic [31:0]            r;
  logic                   e;
  int                     bad_count = 0;
  int                     compares = 0;
  localparam logic [63:0] DW = 64'h0123_4567_89AB_CDEF;

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  igw_error_flags dut (.mclk(mclk), .sys_rst(sys_rst), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_resume(host_resume), .host_word_taken(host_word_taken), .out_word(out_word),
    .out_word_valid(out_word_valid), .out_disconnect(out_disconnect), .out_active(out_active), .io_irq(io_irq));
  igw_host_model host (.mclk(mclk), .sys_rst(sys_rst), .hold(hold), .take_delay(4'h2),
    .out_word_valid(out_word_valid), .out_disconnect(out_disconnect), .host_resume(host_resume),
    .host_word_taken(host_word_taken));

  // hamming positions skip powers of two; bit 6 makes overall parity even
  function automatic logic [6:0] enc(input logic [31:0] d);
    logic [6:0] c;
    int         p;
    c = 7'h00;
    p = 2;
    for (int k = 0; k < 32; k++) begin
      p = p + 1;
      if ((p & (p - 1)) == 0) p = p + 1;
      if (d[k]) c[5:0] = c[5:0] ^ p[5:0];
    end
    c[6] = ^{d, c[5:0]};
    return c;
  endfunction : enc

  function automatic logic [5:0] pos(input int i);
    logic [6:0] c;
    c = enc(32'h0000_0001 << i);
    return c[5:0];
  endfunction : pos

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
  endtask : apb

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, x);
  endtask : rd

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(negedge mclk);
  endtask : wr

  // flips applied after the check bits are made from the clean word
  task automatic send(input logic [63:0] f, input logic [13:0] cf);
    wr(OFS_DATA_LO, DW[31:0] ^ f[31:0]);
    wr(OFS_DATA_HI, DW[63:32] ^ f[63:32]);
    wr(OFS_CHECK, {18'h0_0000, {enc(DW[63:32]), enc(DW[31:0])} ^ cf});
  endtask : send

  initial begin
    req     = '0;
    sys_rst = 1'b1;
    hold    = 1'b1;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(OFS_IRQ_FLAGS, 32'h0000_0000);
    rd(OFS_IRQ_MASK, MASK_RESET);
    rd(OFS_IO_ERROR, 32'h0000_0000);
    chk(pready, 1'b1);
    $display("test reset_values done");
    send(64'h0, 14'h0000);
    chk(out_word, DW);
    rd(OFS_IRQ_FLAGS, 32'h0000_0000);
    send(64'h20, 14'h0000);
    chk(out_word, DW);
    rd(OFS_SYNDROME, {25'h000_0000, 1'b1, pos(5)});
    send(64'h0000_0001_0000_0000, 14'h0000);
    rd(OFS_IRQ_FLAGS, 32'h0000_0002);
    rd(OFS_SYNDROME, {18'h0_0000, 1'b1, pos(0), 7'h00});
    wr(OFS_IRQ_MASK, 32'h0000_0002);
    chk(io_irq, 1'b1);
    wr(OFS_IRQ_MASK, 32'h0000_0004);
    chk(io_irq, 1'b0);
    send(64'h204, 14'h0000);
    chk(out_word, DW ^ 64'h204);
    rd(OFS_IRQ_FLAGS, 32'h0000_0004);
    chk(io_irq, 1'b1);
    rd(OFS_SYNDROME, {25'h000_0000, 1'b0, pos(2) ^ pos(9)});
    send(64'h0000_0100_0000_0000, 14'h0000);
    send(64'h0000_0006_0000_0000, 14'h0000);
    rd(OFS_IRQ_FLAGS, 32'h0000_0004);
    rd(OFS_SYNDROME, {25'h000_0000, 1'b0, pos(2) ^ pos(9)});
    wr(OFS_SYN_CLR, 32'h0000_0000);
    rd(OFS_IRQ_FLAGS, 32'h0000_0000);
    rd(OFS_SYNDROME, {25'h000_0000, 1'b0, pos(2) ^ pos(9)});
    $display("test secded_flags done");
    @(posedge mclk);
    hold <= 1'b0;
    for (int n = 0; n < 20 && out_word_valid !== 1'b0; n++) @(negedge mclk);
    chk(out_word_valid, 1'b0);
    if (out_word_valid !== 1'b0) begin
      report_and_stop();
    end
    rd(OFS_IRQ_FLAGS, 32'h0000_0400);
    wr(OFS_IRQ_FLAGS, 32'h0000_0400);
    rd(OFS_IRQ_FLAGS, 32'h0000_0000);
    wr(OFS_DISCONNECT, 32'h0000_0000);
    @(negedge mclk);
    chk(host.disc_count, 1);
    chk(out_active, 1'b0);
    $display("test drain_disconnect done");
    host.pulse_resume();
    @(negedge mclk);
    rd(OFS_IO_ERROR, 32'h0000_0800);
    rd(OFS_IRQ_FLAGS, 32'h0000_0800);
    wr(OFS_IRQ_MASK, 32'h0000_0800);
    chk(io_irq, 1'b1);
    wr(OFS_CLEAR, 32'h0000_0100);
    rd(OFS_IO_ERROR, 32'h0000_0800);
    wr(OFS_CLEAR, 32'h0000_0000);
    rd(OFS_IO_ERROR, 32'h0000_0000);
    @(posedge mclk);
    hold <= 1'b1;
    send(64'h0, 14'h0000);
    chk(out_active, 1'b1);
    host.pulse_resume();
    @(negedge mclk);
    rd(OFS_IO_ERROR, 32'h0000_0000);
    wr(OFS_CLEAR, 32'h0000_0040);
    chk(out_word_valid, 1'b0);
    wr(OFS_CLEAR, 32'h0000_0002);
    chk(out_active, 1'b0);
    $display("test sequence_clear done");
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(e, 1'b1);
    chk(r, 32'h0000_0000);
    $display("test unmapped done");
    report_and_stop();
  end
endmodule : io_gateway_error_secded_flags_tb_top
